// ==== input_capture_unit.sv ====
// Purpose: multi-channel input capture with per-channel FIFO and interrupts
// Assumes: timer counts and cpu sleep/idle levels come from core_clk_in logic
// Notes: register port returns read data in the cycle after the read strobe
// Summary of operation
// - each qualifying pin event stores the full 16-bit selected timer count
// - up to eight channels, each with own control, buffer and interrupt
// - mode 001 both edges, 010 falling edges, 011 rising edges
// - mode 100 every fourth rising edge, 101 every sixteenth rising edge
// - modes 000 and 110 leave the channel disabled
// - mode 111 is a rising-edge interrupt only in sleep or idle
// - captures queue in a four-entry FIFO
// - interrupt after every 1st, 2nd, 3rd or 4th capture by field value
// - both-edges mode interrupts on every capture regardless of that field
// - timer select 1 takes the first timer, 0 the second
// - read-only overflow flag, set on overflow, cleared by hardware
// - read-only flag high while the FIFO holds an unread value
// - idle-halt bit set stops the channel's captures during cpu idle
// - a pin edge can wake the device from sleep and idle
// - only channels zero and one raise DMA requests
`timescale 1ns/1ps
module input_capture_unit #(
   parameter int NUM_CHANNELS = 8,
   parameter int FIFO_DEPTH = 4,
   parameter int DMA_CHANNELS = 2
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [capture_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [capture_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [capture_pkg::DATA_W-1:0] reg_rdata_out,
   // capture pins and time bases
   input wire logic [NUM_CHANNELS-1:0] capture_input_pin_in,
   input wire logic [capture_pkg::TIMER_W-1:0] first_timer_count_in,
   input wire logic [capture_pkg::TIMER_W-1:0] second_timer_count_in,
   // power state
   input wire logic cpu_idle_in,
   input wire logic cpu_sleep_in,
   // events
   output logic irq_out,
   output logic wake_out,
   output logic [DMA_CHANNELS-1:0] dma_req_out
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   localparam int DW = capture_pkg::DATA_W;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel state
   logic [capture_pkg::MODE_W-1:0] mode [NUM_CHANNELS];
   logic [capture_pkg::ICI_W-1:0] ici [NUM_CHANNELS];
   logic [capture_pkg::ICI_W-1:0] cap_cnt [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] tsel;
   logic [NUM_CHANNELS-1:0] halt;
   logic [NUM_CHANNELS-1:0] ovf;
   logic [NUM_CHANNELS-1:0] cap_evt;
   logic [NUM_CHANNELS-1:0] wake_evt;
   logic [NUM_CHANNELS-1:0] push;
   logic [NUM_CHANNELS-1:0] pop;
   logic [NUM_CHANNELS-1:0] empty;
   logic [NUM_CHANNELS-1:0] full;
   logic [NUM_CHANNELS-1:0] run;
   logic [NUM_CHANNELS-1:0] mode_off;
   logic [NUM_CHANNELS-1:0] buf_rd;
   logic [NUM_CHANNELS-1:0] ctrl_wr;
   logic [NUM_CHANNELS-1:0] irq_evt;
   logic [CW-1:0] fill [NUM_CHANNELS];
   logic [DW-1:0] ctrl_word [NUM_CHANNELS];
   logic [DW-1:0] fifo_word [NUM_CHANNELS];

   // shared register state
   logic [NUM_CHANNELS-1:0] irq_status;
   logic [NUM_CHANNELS-1:0] irq_mask;
   logic [NUM_CHANNELS-1:0] next_irq_status;
   logic [DW-1:0] rd_word;
   logic [DW-1:0] next_rd_word;
   logic rd_from_fifo;
   logic [2:0] rd_ch;
   logic low_power;

   assign low_power = cpu_sleep_in | cpu_idle_in;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   ////////////////////////////////////////////////////////////////////////////
   // channels
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
         chan_if cif ();

         assign ctrl_wr[g] = reg_wr_in && reg_addr_in == capture_pkg::ctrl_addr(3'(g));
         assign buf_rd[g] = reg_rd_in && reg_addr_in == capture_pkg::buf_addr(3'(g));
         assign mode_off[g] = mode[g] == capture_pkg::MODE_OFF ||
                              mode[g] == capture_pkg::MODE_UNUSED;
         // timers freeze in sleep, so only the wake mode acts there
         assign run[g] = ~cpu_sleep_in & ~(cpu_idle_in & halt[g]);

         assign cif.mode = mode[g];
         assign cif.run = run[g];
         assign cif.low_power = low_power;
         assign cap_evt[g] = cif.cap_evt;
         assign wake_evt[g] = cif.wake_evt;

         capture_detector u_det (
            .core_clk_in(core_clk_in),
            .rstn_in(rstn_in),
            .pin_in(capture_input_pin_in[g]),
            .cif(cif.det)
         );

         // a capture into a full buffer is dropped, stored words stay
         assign push[g] = cap_evt[g] & ~full[g];
         assign pop[g] = buf_rd[g] & ~empty[g];

         capture_fifo #(
            .WIDTH(capture_pkg::TIMER_W),
            .DEPTH(FIFO_DEPTH)
         ) u_fifo (
            .core_clk_in(core_clk_in),
            .rstn_in(rstn_in),
            .flush_in(mode_off[g]),
            .push_in(push[g]),
            .push_data_in(tsel[g] ? first_timer_count_in : second_timer_count_in),
            .pop_in(pop[g]),
            .pop_data_out(fifo_word[g]),
            .empty_out(empty[g]),
            .full_out(full[g]),
            .count_out(fill[g])
         );

         always_ff @(posedge core_clk_in) begin
            if (!rstn_in) begin
               mode[g] <= capture_pkg::CTRL_RESET[capture_pkg::MODE_LSB +: capture_pkg::MODE_W];
               ici[g] <= capture_pkg::CTRL_RESET[capture_pkg::ICI_LSB +: capture_pkg::ICI_W];
               tsel[g] <= capture_pkg::CTRL_RESET[capture_pkg::TSEL_BIT];
               halt[g] <= capture_pkg::CTRL_RESET[capture_pkg::HALT_BIT];
            end else if (ctrl_wr[g]) begin
               mode[g] <= reg_wdata_in[capture_pkg::MODE_LSB +: capture_pkg::MODE_W];
               ici[g] <= reg_wdata_in[capture_pkg::ICI_LSB +: capture_pkg::ICI_W];
               tsel[g] <= reg_wdata_in[capture_pkg::TSEL_BIT];
               halt[g] <= reg_wdata_in[capture_pkg::HALT_BIT];
            end
         end

         // overflow clears on a buffer read, but a new overflow wins
         always_ff @(posedge core_clk_in) begin
            if (!rstn_in || mode_off[g]) begin
               ovf[g] <= 1'b0;
            end else if (cap_evt[g] && full[g]) begin
               ovf[g] <= 1'b1;
            end else if (buf_rd[g]) begin
               ovf[g] <= 1'b0;
            end
         end

         // captures-per-interrupt counter
         always_ff @(posedge core_clk_in) begin
            if (!rstn_in || mode_off[g] || mode[g] == capture_pkg::MODE_BOTH) begin
               cap_cnt[g] <= '0;
            end else if (push[g]) begin
               cap_cnt[g] <= (cap_cnt[g] == ici[g]) ? '0 : cap_cnt[g] + 2'h1;
            end
         end

         assign irq_evt[g] = wake_evt[g] |
                             (push[g] & ((mode[g] == capture_pkg::MODE_BOTH) |
                                         (cap_cnt[g] == ici[g])));

         assign ctrl_word[g] = {2'h0, halt[g], 5'h0, tsel[g], ici[g], ovf[g],
                                ~empty[g], mode[g]};

         //////////////////////////////////////////////////////////////////////
         // checks
         sequence s_cap_full;
            cap_evt[g] && full[g];
         endsequence
         sequence s_ovf_kept;
            ovf[g] && $stable(fill[g]);
         endsequence

         full_ovf_a: assert property (s_cap_full and !buf_rd[g] and !mode_off[g] |=> s_ovf_kept)
            else $error("capture into full buffer did not flag overflow");
         disabled_quiet_a: assert property (mode_off[g] |-> !push[g] && !irq_evt[g])
            else $error("disabled channel captured");
         timer_pick_a: assert property (push[g] && !pop[g] && fill[g] == '0 ##1 buf_rd[g]
            |=> fifo_word[g] == (tsel[g] ? $past(first_timer_count_in, 2)
                                         : $past(second_timer_count_in, 2)))
            else $error("captured value not from selected timer");
         read_pops_a: assert property (buf_rd[g] && !empty[g] && !push[g]
            |=> fill[g] == $past(fill[g]) - CW'(1))
            else $error("buffer read did not remove one word");
         bne_shows_a: assert property (push[g] && fill[g] == '0 && !mode_off[g]
            |=> ctrl_word[g][capture_pkg::BNE_BIT])
            else $error("not-empty flag missing after capture");
         idle_halt_a: assert property (cpu_idle_in && halt[g] |-> !push[g])
            else $error("halted channel captured in idle");
         both_irq_a: assert property (mode[g] == capture_pkg::MODE_BOTH && push[g]
            |=> irq_status[g])
            else $error("both-edge capture raised no interrupt");
         wake_mode_a: assert property (mode[g] == capture_pkg::MODE_WAKE |-> !push[g])
            else $error("wake mode stored a capture");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, mask and outputs
   always_comb begin
      next_irq_status = irq_status;
      if (reg_wr_in && reg_addr_in == capture_pkg::IRQ_STATUS_OFS) begin
         next_irq_status = irq_status & ~reg_wdata_in[NUM_CHANNELS-1:0];
      end
      // a new event in the clearing cycle stays set
      next_irq_status = next_irq_status | irq_evt;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         irq_mask <= capture_pkg::IRQ_MASK_RESET[NUM_CHANNELS-1:0];
      end else if (reg_wr_in && reg_addr_in == capture_pkg::IRQ_MASK_OFS) begin
         irq_mask <= reg_wdata_in[NUM_CHANNELS-1:0];
      end
   end

   assign irq_out = |(irq_status & irq_mask);

   // any channel interrupt while sleeping or idle asks for wake-up
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         wake_out <= 1'b0;
      end else begin
         wake_out <= low_power & |irq_evt;
      end
   end

   // per-capture requests, only the first two channels have them
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         dma_req_out <= '0;
      end else begin
         dma_req_out <= push[DMA_CHANNELS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read path
   always_comb begin
      next_rd_word = '0;
      if (reg_addr_in == capture_pkg::IRQ_STATUS_OFS) begin
         next_rd_word = DW'(irq_status);
      end else if (reg_addr_in == capture_pkg::IRQ_MASK_OFS) begin
         next_rd_word = DW'(irq_mask);
      end else begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (reg_addr_in == capture_pkg::ctrl_addr(3'(i))) begin
               next_rd_word = ctrl_word[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         rd_word <= '0;
         rd_from_fifo <= 1'b0;
         rd_ch <= '0;
      end else begin
         rd_word <= reg_rd_in ? next_rd_word : '0;
         rd_from_fifo <= |buf_rd;
         rd_ch <= reg_addr_in[3:1];
      end
   end

   // buffer words come straight from the fifo output register
   always_comb begin
      reg_rdata_out = rd_word;
      if (rd_from_fifo) begin
         reg_rdata_out = '0;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (rd_ch == 3'(i)) begin
               reg_rdata_out = DW'(fifo_word[i]);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_single_cap0;
      mode[0] == capture_pkg::MODE_RISE && ici[0] == 2'h0 && push[0];
   endsequence

   every_cap_a: assert property (s_single_cap0 ##1 irq_mask[0] |-> irq_out)
      else $error("single-capture interrupt not raised");
   dma_pulse_a: assert property (push[0] |=> dma_req_out[0] ##1 (dma_req_out[0] == $past(push[0])))
      else $error("dma request does not follow channel capture");
   wake_out_a: assert property (|irq_evt && low_power |=> wake_out)
      else $error("wake request missing in low power");
   set_wins_a: assert property (irq_evt[0] |=> irq_status[0])
      else $error("interrupt event lost");
endmodule : input_capture_unit

// ==== capture_pkg.sv ====
// Purpose: shared constants for the input capture unit
// Assumes: 16-bit register port, at most eight channels
// Notes: channel registers sit in pairs, control word then capture buffer
package capture_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int TIMER_W = 16;
   localparam int MODE_W = 3;
   localparam int ICI_W = 2;
   localparam int PRESCALE_W = 4;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h11;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 16'h0000;
   localparam int HALT_BIT = 13;
   localparam int TSEL_BIT = 7;
   localparam int ICI_LSB = 5;
   localparam int OVF_BIT = 4;
   localparam int BNE_BIT = 3;
   localparam int MODE_LSB = 0;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
   localparam logic [MODE_W-1:0] MODE_BOTH = 3'h1;
   localparam logic [MODE_W-1:0] MODE_FALL = 3'h2;
   localparam logic [MODE_W-1:0] MODE_RISE = 3'h3;
   localparam logic [MODE_W-1:0] MODE_RISE4 = 3'h4;
   localparam logic [MODE_W-1:0] MODE_RISE16 = 3'h5;
   localparam logic [MODE_W-1:0] MODE_UNUSED = 3'h6;
   localparam logic [MODE_W-1:0] MODE_WAKE = 3'h7;
   localparam logic [PRESCALE_W-1:0] LAST_OF_4 = 4'h3;
   localparam logic [PRESCALE_W-1:0] LAST_OF_16 = 4'hf;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [ADDR_W-1:0] ctrl_addr(input logic [2:0] ch);
      ctrl_addr = {1'b0, ch, 1'b0};
   endfunction : ctrl_addr
   function automatic logic [ADDR_W-1:0] buf_addr(input logic [2:0] ch);
      buf_addr = {1'b0, ch, 1'b1};
   endfunction : buf_addr
endpackage : capture_pkg

// ==== chan_if.sv ====
// Purpose: carries mode and run state to a channel's edge detector
// Assumes: one instance per channel
// Notes: events come back as one-cycle pulses
`timescale 1ns/1ps
interface chan_if;
   logic [capture_pkg::MODE_W-1:0] mode;
   logic run;
   logic low_power;
   logic cap_evt;
   logic wake_evt;
   modport det (input mode, input run, input low_power, output cap_evt, output wake_evt);
   modport ctrl (output mode, output run, output low_power, input cap_evt, input wake_evt);
endinterface : chan_if

// ==== capture_detector.sv ====
// Purpose: synchronise a capture pin, find edges, apply the edge prescaler
// Assumes: pin is asynchronous to core_clk_in
// Notes: edge history runs even while halted, so no stale edge fires on resume
`timescale 1ns/1ps
module capture_detector (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // pin and channel state
   input wire logic pin_in,
   chan_if.det cif
);
   logic sync1, sync2, prev;
   logic [capture_pkg::PRESCALE_W-1:0] pre;
   logic [capture_pkg::MODE_W-1:0] mode_seen;
   logic rise, fall;

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         prev <= sync2;
      end
   end
   assign rise = sync2 & ~prev;
   assign fall = ~sync2 & prev;

   // a mode change restarts the edge count
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || cif.mode != mode_seen || !cif.run) begin
         pre <= '0;
      end else if (rise) begin
         pre <= pre + 4'h1;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mode_seen <= capture_pkg::MODE_OFF;
      end else begin
         mode_seen <= cif.mode;
      end
   end

   always_comb begin
      case (cif.mode)
         capture_pkg::MODE_BOTH: cif.cap_evt = cif.run & (rise | fall);
         capture_pkg::MODE_FALL: cif.cap_evt = cif.run & fall;
         capture_pkg::MODE_RISE: cif.cap_evt = cif.run & rise;
         capture_pkg::MODE_RISE4: begin
            cif.cap_evt = cif.run & rise & (pre[1:0] == capture_pkg::LAST_OF_4[1:0]);
         end
         capture_pkg::MODE_RISE16: begin
            cif.cap_evt = cif.run & rise & (pre == capture_pkg::LAST_OF_16);
         end
         default: cif.cap_evt = 1'b0;
      endcase
   end
   assign cif.wake_evt = (cif.mode == capture_pkg::MODE_WAKE) & rise & cif.low_power;
endmodule : capture_detector

// ==== capture_fifo.sv ====
// Purpose: small capture buffer with a registered read word
// Assumes: caller never pushes when full nor pops when empty
// Notes: flush empties it in one cycle; pop_data_out holds the last popped word
`timescale 1ns/1ps
module capture_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // control
   input wire logic flush_in,
   input wire logic push_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic pop_in,
   // status and data
   output logic [WIDTH-1:0] pop_data_out,
   output logic empty_out,
   output logic full_out,
   output logic [$clog2(DEPTH):0] count_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wptr, rptr;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : bump

   always_ff @(posedge core_clk_in) begin
      if (push_in) begin
         mem[wptr] <= push_data_in;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || flush_in) begin
         wptr <= '0;
         rptr <= '0;
         count_out <= '0;
      end else begin
         if (push_in) wptr <= bump(wptr);
         if (pop_in) rptr <= bump(rptr);
         count_out <= count_out + (PW+1)'(push_in) - (PW+1)'(pop_in);
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         pop_data_out <= '0;
      end else if (pop_in) begin
         pop_data_out <= mem[rptr];
      end
   end
   assign empty_out = (count_out == '0);
   assign full_out = (count_out == (PW+1)'(DEPTH));
endmodule : capture_fifo

// ==== pin_source.sv ====
// Purpose: external signal source driving the capture pins
// Assumes: levels are requested by the bench in the core clock domain
// Notes: lag models a slow source; pins are always driven, never released
`timescale 1ns/1ps
module pin_source #(
   parameter int N = 8
) (
   // clock
   input wire logic core_clk_in,
   // requested levels and delay in cycles
   input wire logic [N-1:0] level_in,
   input wire logic [1:0] lag_in,
   // pins toward the device
   output logic [N-1:0] pin_out
);
   logic [N-1:0] hist [4];
   initial begin
      pin_out = '0;
      foreach (hist[i]) hist[i] = '0;
   end
   // pins move only just after a clock edge, never mid-cycle
   always @(posedge core_clk_in) begin
      hist[0] <= level_in;
      for (int i = 1; i < 4; i++) begin
         hist[i] <= hist[i-1];
      end
      pin_out <= (lag_in == 2'h0) ? level_in : hist[lag_in - 2'h1];
   end
endmodule : pin_source

// ==== tb.sv ====
// Purpose: self-checking bench for the input capture unit
// Assumes: channel n control at index 2n, buffer at 2n+1
// Notes: timer values tell which pulse and which edge was captured
`timescale 1ns/1ps
`define CHECK(nm, e, g) check_val(nm, e, g)
module tb;
   localparam logic [4:0] st_ofs = capture_pkg::IRQ_STATUS_OFS;
   localparam logic [4:0] mk_ofs = capture_pkg::IRQ_MASK_OFS;
   logic core_clk_in;
   logic rstn_in;
   logic [capture_pkg::ADDR_W-1:0] reg_addr_in;
   logic [capture_pkg::DATA_W-1:0] reg_wdata_in;
   logic [capture_pkg::DATA_W-1:0] reg_rdata_out;
   logic reg_wr_in;
   logic reg_rd_in;
   logic cpu_idle_in;
   logic cpu_sleep_in;
   logic irq_out;
   logic wake_out;
   logic [1:0] dma_req_out;
   logic [7:0] level;
   logic [7:0] pins;
   logic [1:0] lag;
   logic [15:0] t1;
   logic [15:0] t2;
   int num_errors;
   int samples_checked;
   int cycles;
   int wake_cnt;
   int dma_cnt [2];
   ////////////////////////////////////////
   input_capture_unit input_capture_unit_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .capture_input_pin_in(pins),
      .first_timer_count_in(t1), .second_timer_count_in(t2), .cpu_idle_in(cpu_idle_in),
      .cpu_sleep_in(cpu_sleep_in), .irq_out(irq_out), .wake_out(wake_out),
      .dma_req_out(dma_req_out));
   pin_source pin_source_inst (.core_clk_in(core_clk_in), .level_in(level), .lag_in(lag),
      .pin_out(pins));
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      cycles++;
      wake_cnt += (wake_out === 1'b1);
      dma_cnt[0] += (dma_req_out[0] === 1'b1);
      dma_cnt[1] += (dma_req_out[1] === 1'b1);
      if (cycles == 6000) begin
         num_errors++;
         conclude();
      end
   end
   ////////////////////////////////////////
   function automatic logic [4:0] ca(input int ch);
      ca = 5'(2 * ch);
   endfunction : ca
   function automatic logic [15:0] ctl(input logic [2:0] m, input logic [1:0] ici,
                                       input logic ts, input logic h);
      ctl = {2'h0, h, 5'h00, ts, ici, 2'h0, m};
   endfunction : ctl
   task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : check_val
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      `CHECK(nm, e, reg_rdata_out);
   endtask : rchk
   task automatic irqchk(input logic e);
      #1;
      `CHECK("irq_out", {15'h0, e}, {15'h0, irq_out});
   endtask : irqchk
   // rising edge marks t1 with a000|n, falling edge with b000|n
   task automatic pulse(input int ch, input logic [15:0] n);
      @(posedge core_clk_in);
      t1 <= 16'ha000 | n;
      level[ch] <= 1'b1;
      repeat (8) @(posedge core_clk_in);
      t1 <= 16'hb000 | n;
      level[ch] <= 1'b0;
      repeat (8) @(posedge core_clk_in);
   endtask : pulse
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////
   initial begin
      rstn_in = 1'b0;
      {reg_wr_in, reg_rd_in, cpu_idle_in, cpu_sleep_in} = 4'h0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      {level, lag, t1} = '0;
      t2 = 16'h5a5a;
      repeat (4) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      rchk("ctrl", ca(0), capture_pkg::CTRL_RESET);
      rchk("mask", mk_ofs, capture_pkg::IRQ_MASK_RESET);
      wr(5'h12, 16'hffff);
      rchk("unmapped", 5'h12, 16'h0000);
      wr(mk_ofs, 16'h0001);
      for (int m = 1; m <= 3; m++) begin
         wr(ca(0), ctl(3'(m), 2'h0, 1'b1, 1'b0));
         pulse(0, 16'(m));
         irqchk(1'b1);
         rchk("ctrl", ca(0), ctl(3'(m), 2'h0, 1'b1, 1'b0) | 16'h0008);
         if (m != 2) rchk("rise", ca(0) + 5'h1, 16'ha000 | 16'(m));
         if (m != 3) rchk("fall", ca(0) + 5'h1, 16'hb000 | 16'(m));
         rchk("ctrl", ca(0), ctl(3'(m), 2'h0, 1'b1, 1'b0));
         wr(st_ofs, 16'h0001);
         irqchk(1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         wr(ca(0), ctl(3'(k == 0 ? 4 : k == 1 ? 5 : k == 2 ? 0 : 6), 2'h0, 1'b1, 1'b0));
         for (int n = 1; n <= 16; n++) pulse(0, 16'(n));
         for (int n = 4; n <= 16; n += 4) begin
            if (k == 0 || (k == 1 && n == 16)) rchk("pre", 5'h1, 16'ha000 | 16'(n));
         end
         rchk("bne", 5'h0, ctl(3'(k == 0 ? 4 : k == 1 ? 5 : k == 2 ? 0 : 6), 2'h0, 1'b1,
                               1'b0));
      end
      wr(ca(0), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      for (int n = 1; n <= 5; n++) pulse(0, 16'(n));
      rchk("ovf", ca(0), ctl(3'h3, 2'h0, 1'b1, 1'b0) | 16'h0018);
      for (int n = 1; n <= 4; n++) rchk("fifo", 5'h1, 16'ha000 | 16'(n));
      rchk("ovf", ca(0), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      lag <= 2'h3;
      wr(ca(7), ctl(3'h3, 2'h0, 1'b0, 1'b0));
      pulse(7, 16'h1);
      rchk("tsel", ca(7) + 5'h1, 16'h5a5a);
      rchk("ch0", ca(0), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      dma_cnt = '{0, 0};
      wr(ca(1), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      wr(ca(2), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      pulse(1, 16'h1);
      pulse(1, 16'h2);
      pulse(2, 16'h3);
      `CHECK("dma1", 16'h2, 16'(dma_cnt[1]));
      `CHECK("dma0", 16'h0, 16'(dma_cnt[0]));
      wr(mk_ofs, 16'h0002);
      for (int ici = 0; ici < 4; ici++) begin
         wr(ca(1), 16'h0000);
         wr(st_ofs, 16'hffff);
         wr(ca(1), ctl(3'h3, 2'(ici), 1'b1, 1'b0));
         for (int n = 0; n <= ici; n++) begin
            pulse(1, 16'(n));
            irqchk(n == ici);
         end
      end
      wr(mk_ofs, 16'h0000);
      irqchk(1'b0);
      rchk("status", st_ofs, 16'h0002);
      wr(mk_ofs, 16'h0002);
      wr(st_ofs, 16'h0002);
      // buffer is still full from the last loop: flush it so the both-edge capture lands
      wr(ca(1), 16'h0000);
      wr(ca(1), ctl(3'h1, 2'h3, 1'b1, 1'b0));
      pulse(1, 16'h9);
      irqchk(1'b1);
      cpu_idle_in <= 1'b1;
      wr(ca(3), ctl(3'h3, 2'h0, 1'b1, 1'b1));
      pulse(3, 16'h1);
      rchk("halt", ca(3), ctl(3'h3, 2'h0, 1'b1, 1'b1));
      wr(ca(3), ctl(3'h3, 2'h0, 1'b1, 1'b0));
      pulse(3, 16'h2);
      rchk("run", ca(3), ctl(3'h3, 2'h0, 1'b1, 1'b0) | 16'h0008);
      cpu_idle_in <= 1'b0;
      cpu_sleep_in <= 1'b1;
      wr(st_ofs, 16'hffff);
      wr(ca(4), ctl(3'h7, 2'h0, 1'b1, 1'b0));
      wake_cnt = 0;
      pulse(4, 16'h1);
      `CHECK("wake", 16'h1, 16'(wake_cnt));
      rchk("wstat", st_ofs, 16'h0010);
      rchk("wbne", ca(4), ctl(3'h7, 2'h0, 1'b1, 1'b0));
      cpu_sleep_in <= 1'b0;
      pulse(4, 16'h2);
      `CHECK("wake", 16'h1, 16'(wake_cnt));
      conclude();
   end
endmodule : tb
